/* File: ssc_pkg.sv */
package ssc_pkg;
    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_SHLEN  = 8'h04;
    localparam logic [7:0] OFS_PATTOT = 8'h08;
    localparam logic [7:0] OFS_WARM   = 8'h0C;
    localparam logic [7:0] OFS_CAPCYC = 8'h10;
    localparam logic [7:0] OFS_SHARE  = 8'h14;
    localparam logic [7:0] OFS_STAT   = 8'h18;
    localparam int CTRL_MODE  = 0;
    localparam int CTRL_START = 1;
    localparam int CTRL_ABORT = 2;
    localparam logic [1:0] RESP_OK  = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // ----------------------------------------------------------------
    // sequencing constants
    // ----------------------------------------------------------------
    localparam int PAUSE_CYC = 8;      // build choice, 2..8 only
    localparam int NUM_SEQ   = 4;      // capture sequences configured
    localparam int WARM_W    = 8;
    localparam int CAP_W     = 4;      // holds up to 15 cycles
    localparam int PAT_W     = 16;
    localparam logic [CAP_W-1:0] CAP_MAX = 4'hF;
    localparam logic [15:0] SHLEN_RST  = 16'h0010;
    localparam logic [15:0] PATTOT_RST = 16'h0100;
    localparam logic [23:0] SHARE_RST  = 24'hC08040;
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_SHIFT  = 3'h1,
        ST_SPAUSE = 3'h3,
        ST_CAPT   = 3'h2,
        ST_CPAUSE = 3'h6,
        ST_DONE   = 3'h7
    } ssc_state_e;
    // controls toward clock controller and pattern logic
    typedef struct packed {
        logic shift_clock;
        logic scan_enable;
        logic capture_en;
        logic capture_window;
        logic gen_clk_en;
        logic misr_en;
    } ssc_scan_s;
endpackage : ssc_pkg

/* File: ssc_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
module ssc_sequencer (
    input  wire logic                 clock,         // self-test clock
    input  wire logic                 reset,         // sync, active high
    input  wire logic [7:0]           s_axi_awaddr,  // write address
    input  wire logic                 s_axi_awvalid, // write addr valid
    output logic                      s_axi_awready, // write addr ready
    input  wire logic [31:0]          s_axi_wdata,   // write data
    input  wire logic [3:0]           s_axi_wstrb,   // byte enables
    input  wire logic                 s_axi_wvalid,  // write data valid
    output logic                      s_axi_wready,  // write data ready
    output logic [1:0]                s_axi_bresp,   // write response
    output logic                      s_axi_bvalid,  // response valid
    input  wire logic                 s_axi_bready,  // response ready
    input  wire logic [7:0]           s_axi_araddr,  // read address
    input  wire logic                 s_axi_arvalid, // read addr valid
    output logic                      s_axi_arready, // read addr ready
    output logic [31:0]               s_axi_rdata,   // read data
    output logic [1:0]                s_axi_rresp,   // read response
    output logic                      s_axi_rvalid,  // read valid
    input  wire logic                 s_axi_rready,  // read ready
    output ssc_pkg::ssc_scan_s        scan_o,        // scan controls
    output logic [1:0]                seq_index      // capture sequence
);
    import ssc_pkg::*;

    // ----------------------------------------------------------------
    // registers and state
    // ----------------------------------------------------------------
    logic                mode_q;
    logic [15:0]         shlen_q;
    logic [PAT_W-1:0]    pattot_q;
    logic [WARM_W-1:0]   warm_q;
    logic [CAP_W-1:0]    capcyc_q;
    logic [23:0]         share_q;
    logic                done_q;
    logic                warm_act_q;
    ssc_state_e          st_q;
    logic [15:0]         cnt_q;
    logic [PAT_W-1:0]    pat_q;
    logic                shclk_q;
    logic                scan_en_q;
    logic [1:0]          idx_q;
    logic                aw_got_q, w_got_q;
    logic [7:0]          awaddr_q;
    logic [31:0]         wdata_q;
    logic [3:0]          wstrb_q;
    logic                do_wr;
    logic                start, abort;
    logic [CAP_W-1:0]    cap_len;
    logic [31:0]         shlen_m, pattot_m, share_m;
    logic [CAP_W:0]      capt_run_q;

    // merge data under byte enables
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // pick the sequence whose share holds this pattern slot
    function automatic logic [1:0] seq_of(input logic [7:0]  slot,
                                          input logic [23:0] bnd);
        logic [1:0] r;
        r = 2'h0;
        for (int i = 0; i < NUM_SEQ - 1; i++) begin
            if (slot >= bnd[i*8 +: 8]) begin
                r = 2'(i + 1);
            end
        end
        return r;
    endfunction : seq_of

    // ----------------------------------------------------------------
    // bus write side
    // ----------------------------------------------------------------
    assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
    assign do_wr         = aw_got_q && w_got_q && !s_axi_bvalid;
    assign start = do_wr && awaddr_q == OFS_CTRL && wstrb_q[0]
                   && wdata_q[CTRL_START];
    assign abort = do_wr && awaddr_q == OFS_CTRL && wstrb_q[0]
                   && wdata_q[CTRL_ABORT];

    // address and data may arrive in either order
    always_ff @(posedge clock) begin
        if (reset) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q  <= 32'h0;
            wstrb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
            end
        end
    end

    // response one cycle after both halves are held
    always_ff @(posedge clock) begin
        if (reset) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OK;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awaddr_q > OFS_STAT || awaddr_q[1:0] != 2'h0)
                            ? RESP_ERR : RESP_OK;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // merged words for the strobed registers
    assign shlen_m  = merge({16'h0, shlen_q}, wdata_q, wstrb_q);
    assign pattot_m = merge({16'h0, pattot_q}, wdata_q, wstrb_q);
    assign share_m  = merge({8'h0, share_q}, wdata_q, wstrb_q);

    // config registers; writes while busy would upset the run
    always_ff @(posedge clock) begin
        if (reset) begin
            mode_q   <= 1'b0;
            shlen_q  <= SHLEN_RST;
            pattot_q <= PATTOT_RST;
            capcyc_q <= '0;
            share_q  <= SHARE_RST;
        end else if (do_wr) begin
            unique case (awaddr_q)
                OFS_CTRL:   mode_q <= wstrb_q[0] ? wdata_q[CTRL_MODE]
                                                 : mode_q;
                OFS_SHLEN:  shlen_q <= shlen_m[15:0];
                OFS_PATTOT: pattot_q <= pattot_m[15:0];
                OFS_CAPCYC: capcyc_q <= wstrb_q[0] ? wdata_q[CAP_W-1:0]
                                                   : capcyc_q;
                OFS_SHARE:  share_q <= share_m[23:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // bus read side
    // ----------------------------------------------------------------
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge clock) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= RESP_OK;
            unique case (s_axi_araddr)
                OFS_CTRL:   s_axi_rdata <= {31'h0, mode_q};
                OFS_SHLEN:  s_axi_rdata <= {16'h0, shlen_q};
                OFS_PATTOT: s_axi_rdata <= {16'h0, pattot_q};
                OFS_WARM:   s_axi_rdata <= {24'h0, warm_q};
                OFS_CAPCYC: s_axi_rdata <= {28'h0, capcyc_q};
                OFS_SHARE:  s_axi_rdata <= {8'h0, share_q};
                OFS_STAT:   s_axi_rdata <= {pat_q, 10'h0, st_q,
                                            warm_act_q, done_q,
                                            st_q != ST_IDLE};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= RESP_ERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // pattern sequencer
    // ----------------------------------------------------------------
    // unprogrammed capture count falls back to the counter maximum
    assign cap_len = (capcyc_q == '0) ? CAP_MAX : capcyc_q;

    // shift, pause, capture, pause per pattern
    always_ff @(posedge clock) begin
        if (reset) begin
            st_q    <= ST_IDLE;
            cnt_q   <= 16'h0;
            pat_q   <= '0;
            shclk_q <= 1'b0;
        end else if (abort) begin
            st_q    <= ST_IDLE;
            shclk_q <= 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE, ST_DONE: begin
                    if (start && mode_q) begin
                        st_q  <= ST_SHIFT;
                        cnt_q <= shlen_q;
                        pat_q <= '0;
                    end
                end
                ST_SHIFT: begin
                    // one shift clock every two cycles
                    shclk_q <= !shclk_q;
                    if (shclk_q) begin
                        cnt_q <= cnt_q - 16'h1;
                        if (cnt_q <= 16'h1) begin
                            st_q  <= ST_SPAUSE;
                            cnt_q <= 16'(PAUSE_CYC - 1);
                        end
                    end
                end
                ST_SPAUSE: begin
                    cnt_q <= cnt_q - 16'h1;
                    if (cnt_q == 16'h0) begin
                        st_q  <= ST_CAPT;
                        cnt_q <= {12'h0, cap_len} - 16'h1;
                    end
                end
                ST_CAPT: begin
                    cnt_q <= cnt_q - 16'h1;
                    if (cnt_q == 16'h0) begin
                        st_q  <= ST_CPAUSE;
                        cnt_q <= 16'(PAUSE_CYC - 1);
                    end
                end
                ST_CPAUSE: begin
                    cnt_q <= cnt_q - 16'h1;
                    if (cnt_q == 16'h0) begin
                        pat_q <= pat_q + 1'b1;
                        cnt_q <= shlen_q;
                        st_q  <= (pat_q + 1'b1 >= pattot_q)
                                 ? ST_DONE : ST_SHIFT;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // scan enable drops one cycle into the shift pause and rises one
    // cycle before the capture pause ends, so it never moves with capture boundaries
    always_ff @(posedge clock) begin
        if (reset) begin
            scan_en_q <= 1'b1;
        end else if (st_q == ST_SPAUSE && cnt_q == 16'(PAUSE_CYC - 1)) begin
            scan_en_q <= 1'b0;
        end else if (st_q == ST_CPAUSE && cnt_q == 16'h1) begin
            scan_en_q <= 1'b1;
        end else if (st_q == ST_IDLE || st_q == ST_DONE) begin
            scan_en_q <= 1'b1;
        end
    end

    // warm-up tracking; start re-arms, end copies pattern count in
    always_ff @(posedge clock) begin
        if (reset) begin
            warm_q     <= '0;
            warm_act_q <= 1'b0;
        end else if (do_wr && awaddr_q == OFS_WARM && wstrb_q[0]) begin
            warm_q <= wdata_q[WARM_W-1:0];
        end else if (start && mode_q) begin
            warm_act_q <= (warm_q != '0);
        end else if (warm_act_q && st_q == ST_CPAUSE && cnt_q == 16'h0
                     && !abort && pat_q + 1'b1 >= PAT_W'(warm_q)) begin
            // drop at the pattern step, so the first counted shift
            // already feeds the signature
            warm_act_q <= 1'b0;
            warm_q     <= WARM_W'(pat_q + 1'b1);
        end
    end

    // done is set by the sequencer, cleared by the next start
    always_ff @(posedge clock) begin
        if (reset) begin
            done_q <= 1'b0;
        end else if (st_q == ST_CPAUSE && cnt_q == 16'h0
                     && pat_q + 1'b1 >= pattot_q) begin
            done_q <= 1'b1;
        end else if (start) begin
            done_q <= 1'b0;
        end
    end

    // index registered so it holds steady across each capture; it follows each pattern step one cycle late
    generate
        if (NUM_SEQ > 1) begin : g_idx
            always_ff @(posedge clock) begin
                if (reset) begin
                    idx_q <= 2'h0;
                end else begin
                    idx_q <= seq_of(pat_q[7:0], share_q);
                end
            end
        end else begin : g_one
            always_ff @(posedge clock) begin
                idx_q <= 2'h0;
            end
        end
    endgenerate

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign seq_index            = idx_q;
    assign scan_o.shift_clock    = shclk_q;
    assign scan_o.scan_enable    = scan_en_q;
    assign scan_o.capture_en     = mode_q & ~scan_en_q;
    assign scan_o.capture_window = (st_q == ST_CAPT);
    // pattern logic clocks only run while shifting
    assign scan_o.gen_clk_en     = (st_q == ST_SHIFT);
    assign scan_o.misr_en        = (st_q == ST_SHIFT)
                                   && !warm_act_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_capt_no_scan;
        @(posedge clock) disable iff (reset)
        st_q == ST_CAPT |-> !scan_en_q;
    endproperty
    a_capt_no_scan: assert property (p_capt_no_scan)
        else $error("scan enable high in capture");

    property p_spause_len;
        @(posedge clock) disable iff (reset)
        $rose(st_q == ST_SPAUSE) |-> (st_q == ST_SPAUSE) [*8]
            ##1 st_q == ST_CAPT;
    endproperty
    a_spause_len: assert property (p_spause_len)
        else $error("shift pause length wrong");

    property p_cpause_len;
        @(posedge clock) disable iff (reset)
        $rose(st_q == ST_CPAUSE) |-> (st_q == ST_CPAUSE) [*8]
            ##1 st_q != ST_CPAUSE;
    endproperty
    a_cpause_len: assert property (p_cpause_len)
        else $error("capture pause length wrong");

    property p_se_fall;
        @(posedge clock) disable iff (reset)
        $rose(st_q == ST_SPAUSE) |=> $fell(scan_en_q);
    endproperty
    a_se_fall: assert property (p_se_fall)
        else $error("scan enable did not fall in pause");

    property p_se_rise;
        @(posedge clock) disable iff (reset)
        $rose(scan_en_q) && st_q != ST_IDLE |-> st_q == ST_CPAUSE;
    endproperty
    a_se_rise: assert property (p_se_rise)
        else $error("scan enable rose outside capture pause");

    // cycles spent in the current capture, for the length check
    always_ff @(posedge clock) begin
        if (reset || st_q != ST_CAPT) begin
            capt_run_q <= '0;
        end else begin
            capt_run_q <= capt_run_q + 1'b1;
        end
    end

    property p_capt_len;
        @(posedge clock) disable iff (reset)
        $fell(st_q == ST_CAPT) && !$past(abort) && capcyc_q == '0 |->
            capt_run_q == {1'b0, CAP_MAX};
    endproperty
    a_capt_len: assert property (p_capt_len)
        else $error("default capture length wrong");

    property p_no_misr_warm;
        @(posedge clock) disable iff (reset)
        warm_act_q |-> !scan_o.misr_en;
    endproperty
    a_no_misr_warm: assert property (p_no_misr_warm)
        else $error("signature updated during warm-up");

    property p_warm_load;
        @(posedge clock) disable iff (reset)
        $fell(warm_act_q) && !$past(start) |->
            warm_q == pat_q[WARM_W-1:0];
    endproperty
    a_warm_load: assert property (p_warm_load)
        else $error("warm-up register not loaded");

    property p_pat_step;
        @(posedge clock) disable iff (reset)
        st_q == ST_CPAUSE && cnt_q == 16'h0 && !abort |=>
            pat_q == $past(pat_q) + 1'b1;
    endproperty
    a_pat_step: assert property (p_pat_step)
        else $error("pattern count did not advance");

    property p_gate_capt;
        @(posedge clock) disable iff (reset)
        st_q == ST_CAPT |-> !scan_o.gen_clk_en && scan_o.capture_en;
    endproperty
    a_gate_capt: assert property (p_gate_capt)
        else $error("pattern clocks on or capture enable low in capture");
endmodule : ssc_sequencer
`default_nettype wire

/* File: ssc_clk_ctrl_model.sv */
`timescale 1ns/100ps
`default_nettype none
module ssc_clk_ctrl_model (
    input  wire logic               clock,     // self-test clock
    input  wire ssc_pkg::ssc_scan_s scan_i,    // scan controls
    input  wire logic [1:0]         seq_index, // sequence to play
    output logic                    clk_out,   // core clock
    output logic [7:0]              pulses     // pulses this window
);
    import ssc_pkg::*;
    // shift clock while scan enable high, else capture burst
    assign clk_out = scan_i.scan_enable ? scan_i.shift_clock
                   : scan_i.capture_window & clock;
    // one pulse per window cycle; every index plays the same burst
    // no synchroniser lag modelled, so pulses never leak out of the window
    always @(posedge clock) begin
        if (scan_i.capture_window)
            pulses <= pulses + 8'h01;
        else if (scan_i.scan_enable)
            pulses <= 8'h00;
    end
endmodule : ssc_clk_ctrl_model
`default_nettype wire

/* File: selftest_shift_capture_sequencer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module selftest_shift_capture_sequencer_tb;
    import ssc_pkg::*;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  aw_a = '0, ar_a = '0;
    logic [31:0] w_d = '0, r_d;
    logic        aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
    logic        aw_r, w_r, b_v, ar_r, r_v, clk_out;
    logic [1:0]  b_rsp, r_rsp, seq_index;
    logic [7:0]  pulses, slot;
    ssc_scan_s   scan_o;
    int          num_errors = 0, num_checks = 0;
    int          pat, idle_n, cap_n, sh_n, exp_sh, exp_cap, warm;
    logic        armed = 0, first, cw_q, gen_q, sc_q;

    ssc_sequencer i_ssc_sequencer (.clock(clock), .reset(reset),
        .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
        .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
        .s_axi_wready(w_r), .s_axi_bresp(b_rsp), .s_axi_bvalid(b_v),
        .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v),
        .s_axi_arready(ar_r), .s_axi_rdata(r_d), .s_axi_rresp(r_rsp),
        .s_axi_rvalid(r_v), .s_axi_rready(r_r), .scan_o(scan_o),
        .seq_index(seq_index));
    ssc_clk_ctrl_model i_ssc_clk_ctrl_model (.clock(clock),
        .scan_i(scan_o), .seq_index(seq_index), .clk_out(clk_out),
        .pulses(pulses));

    always #5 clock = ~clock;

    task chk(input string what, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task conclude;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude

    // bready held from the start; each half dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge clock);
        aw_a <= a;
        w_d  <= d;
        aw_v <= 1'b1;
        w_v  <= 1'b1;
        b_r  <= 1'b1;
        do begin
            @(posedge clock);
            if (aw_v && aw_r) aw_v <= 1'b0;
            if (w_v && w_r) w_v <= 1'b0;
        end while (!b_v);
        b_r <= 1'b0;
        chk("bresp", er, b_rsp);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [1:0] er,
                      output logic [31:0] d);
        @(posedge clock);
        ar_a <= a;
        ar_v <= 1'b1;
        r_r  <= 1'b1;
        do begin
            @(posedge clock);
            if (ar_v && ar_r) ar_v <= 1'b0;
        end while (!r_v);
        r_r <= 1'b0;
        d = r_d;
        chk("rresp", er, r_rsp);
    endtask : rd

    // cycle-by-cycle judge of a run; counts pause, shift and capture
    always @(posedge clock) begin
        if (armed) begin
            chk("capture_en", !scan_o.scan_enable, scan_o.capture_en);
            if (scan_o.capture_window || scan_o.gen_clk_en)
                chk("scan_en", scan_o.gen_clk_en, scan_o.scan_enable);
            if (scan_o.capture_window)
                chk("gen_clk_en", 0, scan_o.gen_clk_en);
            if (scan_o.gen_clk_en)
                chk("misr_en", pat >= warm, scan_o.misr_en);
            if (scan_o.capture_window && !cw_q) begin
                slot = pat[7:0];
                chk("spause", PAUSE_CYC, idle_n);
                chk("shifts", exp_sh, sh_n);
                chk("index", (slot >= SHARE_RST[7:0])
                    + (slot >= SHARE_RST[15:8])
                    + (slot >= SHARE_RST[23:16]), seq_index);
            end
            if (!scan_o.capture_window && cw_q) begin
                chk("capture", exp_cap, cap_n);
                chk("pulses", exp_cap, pulses);
                cap_n = 0;
                sh_n = 0;
                pat++;
            end
            if (scan_o.gen_clk_en && !gen_q && !first)
                chk("cpause", PAUSE_CYC, idle_n);
            if (scan_o.gen_clk_en) first = 0;
            cap_n += scan_o.capture_window;
            sh_n += (scan_o.shift_clock && !sc_q);
            idle_n = (scan_o.capture_window || scan_o.gen_clk_en) ? 0
                   : idle_n + 1;
        end
        cw_q = scan_o.capture_window;
        gen_q = scan_o.gen_clk_en;
        sc_q = scan_o.shift_clock;
    end

    task automatic t_regs;
        logic [31:0] d;
        chk("scan_en rst", 1, scan_o.scan_enable);
        chk("cap_en rst", 0, scan_o.capture_en);
        chk("index rst", 0, seq_index);
        rd(OFS_SHLEN, RESP_OK, d);
        chk("shlen", SHLEN_RST, d);
        rd(OFS_SHARE, RESP_OK, d);
        chk("share", SHARE_RST, d);
        rd(8'h1C, RESP_ERR, d);
        chk("unmapped", 0, d);
        wr(8'h1C, 32'h1, RESP_ERR);
        // start without mode must be ignored
        wr(OFS_CTRL, 32'h2, RESP_OK);
        repeat (4) @(posedge clock);
        chk("refused", 0, scan_o.gen_clk_en);
    endtask : t_regs

    task automatic t_run(input int shl, cap, tot, wm);
        logic [31:0] d;
        int n;
        pat = 0;
        first = 1;
        cap_n = 0;
        sh_n = 0;
        exp_sh = shl;
        exp_cap = (cap == 0) ? CAP_MAX : cap;
        warm = wm;
        wr(OFS_SHLEN, shl, RESP_OK);
        wr(OFS_CAPCYC, cap, RESP_OK);
        wr(OFS_PATTOT, tot, RESP_OK);
        wr(OFS_WARM, wm, RESP_OK);
        wr(OFS_CTRL, 32'h1, RESP_OK);
        armed = 1;
        wr(OFS_CTRL, 32'h3, RESP_OK);
        for (n = 0; n < 10000 && pat < tot; n++) @(posedge clock);
        repeat (2 * PAUSE_CYC) @(posedge clock);
        rd(OFS_STAT, RESP_OK, d);
        chk("done", 1, d[1]);
        armed = 0;
    endtask : t_run

    // watchdog sized well past the longest run
    initial begin
        repeat (12000) @(posedge clock);
        num_errors++;
        $display("MISMATCH watchdog expected finish seen hang");
        conclude;
    end

    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        t_regs;
        t_run(2, 0, 2, 1);
        t_run(1, 1, 257, 0);
        conclude;
    end
endmodule : selftest_shift_capture_sequencer_tb
`default_nettype wire
